//--- logic/audio_in_serial_port.sv
// Overview of operation
// RULE1 - One or two channels, each eight or sixteen bits per sample.
// RULE2 - Samples go to memory by DMA, alternating between two buffers.
// RULE3 - Memory layouts: 8-bit mono, 8-bit stereo, 16-bit mono, 16-bit stereo.
// RULE4 - Little-endian or big-endian byte order chosen by a control bit.
// RULE5 - Drive a programmable oversampling clock output from a phase accumulator.
// RULE6 - Standard I2S framing: MSB first, one bit delay, left and right.
// RULE7 - LSB-first framing with any channel length from one to sixteen.
// RULE8 - Frames up to 512 bits with a sample-valid qualifier bit.
// RULE9 - After reset the port is timing slave; bit clock and select are inputs.
// RULE10 - Slave bit clock is asynchronous and crosses through synchronisers.
// RULE11 - The converter supplies bit clock and drives select and data against it.
// RULE12 - Master mode drives bit clock as whole division of the oversampling clock.
// RULE13 - Bit clock never exceeds 22 MHz, generated or supplied.
// RULE14 - Data sampled on rising or falling bit clock edge by a control bit.
// RULE15 - Slave word select sampled on the same edge as serial data.
// RULE16 - Master word select changes on the edge opposite the sampling edge.
// RULE17 - Master bit clock equals oversampling clock over divider plus one, 0 to 255.
// RULE18 - Master word select from programmable divider, frames of 1 to 512 bits; divider 0 toggles select every bit, giving 2-bit frames.
// RULE19 - Bit zero is sampled on the edge after the select transition edge.
// RULE20 - Qualified mode keeps a frame only if its valid bit matches.
// RULE21 - Each assembled sample reaches the system side exactly once; a word completed while memory is busy is dropped and sets overrun.
`timescale 1ns/10ps
`include "audio_in_regs.svh"

module audio_in_serial_port (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Converter pins
    output logic oversample_clock_out,
    input wire logic serial_bit_clock_in,
    output logic serial_bit_clock_out,
    output logic serial_bit_clock_oe,
    input wire logic frame_word_select_in,
    output logic frame_word_select_out,
    output logic frame_word_select_oe,
    input wire logic serial_data_in,
    // Memory write port
    output logic mem_valid,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_data,
    input wire logic mem_ready
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic [15:0] place_bit(input logic [15:0] acc, input logic b, input logic [4:0] idx,
                                              input logic msb_first);
        if (msb_first) begin
            place_bit = {acc[14:0], b};
        end else begin
            place_bit = acc | (16'({15'h0000, b}) << idx[3:0]);
        end
    endfunction : place_bit

    function automatic logic [15:0] order16(input logic [15:0] v, input logic little);
        order16 = little ? v : {v[7:0], v[15:8]};
    endfunction : order16

    // Software-visible state.
    logic [`CTRL_WIDTH-1:0] ctrl_r;
    logic [31:0] frequency_r, base1_r, base2_r, reg_rdata_r;
    logic [7:0] bit_clock_divider_r;
    logic [8:0] frame_length_divider_r, valid_bit_position_r, left_start_r, right_start_r;
    logic [4:0] data_length_r;
    logic [15:0] buf_words_r;
    logic [1:0] buf_full_r;
    logic overrun_r, active_buf_r;

    wire enable = ctrl_r[`CTRL_ENABLE];
    wire serial_timing_master = ctrl_r[`CTRL_MASTER];
    wire edge_rising = ctrl_r[`CTRL_EDGE_RISING];
    wire ws_polarity = ctrl_r[`CTRL_WS_POLARITY];
    wire [1:0] capture_qualify_mode = ctrl_r[`CTRL_QUAL_HI:`CTRL_QUAL_LO];
    wire [1:0] layout_bits = {ctrl_r[`CTRL_SIZE16], ctrl_r[`CTRL_STEREO]};

    // Register write decode.
    wire wr_ctrl = reg_write & hit(reg_addr, `AIN_CTRL_OFS);
    wire wr_status = reg_write & hit(reg_addr, `AIN_STATUS_OFS);
    wire wr_freq = reg_write & hit(reg_addr, `AIN_FREQUENCY_OFS);
    wire wr_div = reg_write & hit(reg_addr, `AIN_DIVIDER_OFS);
    wire wr_frame_a = reg_write & hit(reg_addr, `AIN_FRAME_A_OFS);
    wire wr_frame_b = reg_write & hit(reg_addr, `AIN_FRAME_B_OFS);
    wire wr_base1 = reg_write & hit(reg_addr, `AIN_BASE1_OFS);
    wire wr_base2 = reg_write & hit(reg_addr, `AIN_BASE2_OFS);
    wire wr_words = reg_write & hit(reg_addr, `AIN_BUF_WORDS_OFS);

    // Oversampling clock: phase accumulator whose top bit is the output square wave.
    // The output cannot exceed half of clk; faster settings alias.
    logic [31:0] dds_acc_r;
    logic os_r;
    wire os_rise = dds_acc_r[31] & ~os_r;

    // Bit clock generator for master mode.
    logic [7:0] sck_cnt_r;
    logic sck_gen_r;
    wire [8:0] sck_half = 9'(({1'b0, bit_clock_divider_r} + 9'h001) >> 1);
    wire [7:0] sck_cnt_nxt = os_rise ? ((sck_cnt_r == bit_clock_divider_r) ? 8'h00 : sck_cnt_r + 8'h01) : sck_cnt_r;
    wire sck_gen_nxt = (bit_clock_divider_r == 8'h00) ? dds_acc_r[31] : ({1'b0, sck_cnt_nxt} < sck_half);
    wire gen_opp_edge = edge_rising ? (sck_gen_r & ~sck_gen_nxt) : (~sck_gen_r & sck_gen_nxt);

    // Word select generator for master mode.
    logic [8:0] ws_cnt_r;
    logic ws_gen_r;
    wire [9:0] ws_half = 10'(({1'b0, frame_length_divider_r} + 10'h001) >> 1);
    wire [8:0] ws_cnt_nxt = (ws_cnt_r == frame_length_divider_r) ? 9'h000 : ws_cnt_r + 9'h001;
    wire ws_gen_nxt = (frame_length_divider_r == 9'h000) ? ~ws_gen_r : ({1'b0, ws_cnt_nxt} < ws_half);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dds_acc_r <= 32'h00000000;
            {os_r, sck_gen_r, ws_gen_r} <= 3'h0;
            {sck_cnt_r, ws_cnt_r} <= 17'h00000;
        end else begin
            dds_acc_r <= dds_acc_r + frequency_r; // RULE5
            os_r <= dds_acc_r[31];
            sck_cnt_r <= sck_cnt_nxt; // RULE17
            sck_gen_r <= sck_gen_nxt; // RULE12
            if (gen_opp_edge) begin // RULE16
                ws_cnt_r <= ws_cnt_nxt; // RULE18
                ws_gen_r <= ws_gen_nxt;
            end
        end
    end

    assign oversample_clock_out = os_r;
    assign serial_bit_clock_out = sck_gen_r;
    assign serial_bit_clock_oe = serial_timing_master; // RULE9
    assign frame_word_select_out = ws_gen_r ^ ~ws_polarity;
    assign frame_word_select_oe = serial_timing_master; // RULE9

    // The generated clock and select go through the same synchroniser as the pins,
    // so data and timing keep their relative delay in either mode.
    wire sck_src = serial_timing_master ? sck_gen_r : serial_bit_clock_in;
    wire ws_src = serial_timing_master ? frame_word_select_out : frame_word_select_in;
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic ws_s1_r, ws_s2_r;
    logic sd_s1_r, sd_s2_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {sck_s1_r, sck_s2_r, sck_s3_r, ws_s1_r, ws_s2_r, sd_s1_r, sd_s2_r} <= 7'h00;
        end else begin
            sck_s1_r <= sck_src; // RULE10
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            ws_s1_r <= ws_src;
            ws_s2_r <= ws_s1_r;
            sd_s1_r <= serial_data_in;
            sd_s2_r <= sd_s1_r;
        end
    end

    // Edges are seen by oversampling, so the bit clock must stay well below clk/2.
    wire sample_edge = edge_rising ? (sck_s2_r & ~sck_s3_r) : (~sck_s2_r & sck_s3_r); // RULE14 RULE13

    // Serial to parallel conversion; the qualifier match is cleared at each frame start.
    logic ws_prev_r, frame_seen_r, qual_bit_r, sample_pulse_r;
    logic [9:0] bitpos_r;
    logic [15:0] left_acc_r, right_acc_r, sample_left_r, sample_right_r;

    wire ws_start = (ws_s2_r != ws_prev_r) && (ws_s2_r == ws_polarity); // RULE15
    wire [9:0] left_end = {1'b0, left_start_r} + {5'h00, data_length_r};
    wire [9:0] right_end = {1'b0, right_start_r} + {5'h00, data_length_r};
    wire in_left = (bitpos_r >= {1'b0, left_start_r}) && (bitpos_r < left_end);
    wire in_right = ctrl_r[`CTRL_STEREO] && (bitpos_r >= {1'b0, right_start_r}) && (bitpos_r < right_end);
    wire [4:0] left_idx = 5'(bitpos_r - {1'b0, left_start_r});
    wire [4:0] right_idx = 5'(bitpos_r - {1'b0, right_start_r});
    wire [15:0] left_nxt = in_left ? place_bit(left_acc_r, sd_s2_r, left_idx, ctrl_r[`CTRL_MSB_FIRST]) : left_acc_r;
    wire [15:0] right_nxt = in_right ? place_bit(right_acc_r, sd_s2_r, right_idx, ctrl_r[`CTRL_MSB_FIRST]) :
        right_acc_r;
    wire [4:0] justify = 5'(5'h10 - data_length_r);
    wire qual_now = (bitpos_r == {1'b0, valid_bit_position_r}) ? (sd_s2_r == capture_qualify_mode[0]) : qual_bit_r;
    wire frame_ok = !capture_qualify_mode[1] || qual_now;
    wire [9:0] bitpos_inc = (bitpos_r == 10'h3ff) ? bitpos_r : bitpos_r + 10'h001;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {ws_prev_r, frame_seen_r, qual_bit_r, sample_pulse_r} <= 4'h0;
            bitpos_r <= 10'h000;
            {left_acc_r, right_acc_r, sample_left_r, sample_right_r} <= 64'h0000000000000000;
        end else begin
            sample_pulse_r <= 1'b0;
            if (sample_edge) begin
                ws_prev_r <= ws_s2_r;
                qual_bit_r <= ws_start ? 1'b0 : qual_now; // RULE8 RULE20
                if (ws_start) begin
                    bitpos_r <= 10'h000; // RULE19
                    frame_seen_r <= 1'b1;
                    left_acc_r <= 16'h0000;
                    right_acc_r <= 16'h0000;
                    if (frame_seen_r && frame_ok) begin // RULE20
                        sample_left_r <= left_nxt << justify; // RULE6 RULE7
                        sample_right_r <= right_nxt << justify;
                        sample_pulse_r <= 1'b1; // RULE21
                    end
                end else begin
                    bitpos_r <= bitpos_inc;
                    left_acc_r <= left_nxt;
                    right_acc_r <= right_nxt;
                end
            end
        end
    end

    // Packing of samples into memory words; byte lane k lands at word address plus k.
    wire [15:0] left16 = order16(sample_left_r, ctrl_r[`CTRL_LITTLE_ENDIAN]); // RULE4
    wire [15:0] right16 = order16(sample_right_r, ctrl_r[`CTRL_LITTLE_ENDIAN]);
    wire [31:0] entry =
        (layout_bits == audio_in_pkg::LAYOUT_8_MONO) ? {24'h000000, sample_left_r[15:8]} :
        (layout_bits == audio_in_pkg::LAYOUT_8_STEREO) ? {16'h0000, sample_right_r[15:8], sample_left_r[15:8]} :
        (layout_bits == audio_in_pkg::LAYOUT_16_MONO) ? {16'h0000, left16} : {right16, left16}; // RULE3 RULE1
    wire [2:0] entry_bytes =
        (layout_bits == audio_in_pkg::LAYOUT_8_MONO) ? 3'h1 :
        (layout_bits == audio_in_pkg::LAYOUT_16_STEREO) ? 3'h4 : 3'h2;

    logic [1:0] fill_r;
    logic [31:0] word_r, mem_addr_r, mem_data_r;
    logic [15:0] word_index_r;
    audio_in_pkg::mem_state_t mem_state_r;

    wire [2:0] fill_total = {1'b0, fill_r} + entry_bytes;
    wire [31:0] packed_word = word_r | (entry << {fill_r, 3'b000});
    wire word_done = enable && sample_pulse_r && (fill_total == 3'h4);
    wire mem_free = (mem_state_r == audio_in_pkg::MEM_IDLE);
    wire emit = word_done && mem_free;
    wire last_word = (word_index_r + 16'h0001) >= buf_words_r;
    wire [31:0] active_base = active_buf_r ? base2_r : base1_r;
    wire [1:0] full_set = (emit && last_word) ? (active_buf_r ? 2'b10 : 2'b01) : 2'b00;
    wire overrun_set = (word_done && !mem_free) || (emit && last_word && buf_full_r[~active_buf_r]);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fill_r <= 2'h0;
            word_r <= 32'h00000000;
            word_index_r <= 16'h0000;
            active_buf_r <= 1'b0;
            mem_state_r <= audio_in_pkg::MEM_IDLE;
            mem_addr_r <= 32'h00000000;
            mem_data_r <= 32'h00000000;
        end else begin
            if (!enable) begin
                fill_r <= 2'h0;
                word_r <= 32'h00000000;
            end else if (sample_pulse_r) begin
                fill_r <= fill_total[1:0];
                word_r <= (fill_total == 3'h4) ? 32'h00000000 : packed_word;
            end
            if (emit) begin
                mem_data_r <= packed_word; // RULE2
                mem_addr_r <= active_base + {14'h0000, word_index_r, 2'b00};
                word_index_r <= last_word ? 16'h0000 : word_index_r + 16'h0001;
                if (last_word) begin
                    active_buf_r <= ~active_buf_r; // RULE2
                end
            end
            case (mem_state_r)
                audio_in_pkg::MEM_IDLE: begin
                    if (emit) begin
                        mem_state_r <= audio_in_pkg::MEM_BUSY;
                    end
                end
                audio_in_pkg::MEM_BUSY: begin
                    if (mem_ready) begin
                        mem_state_r <= audio_in_pkg::MEM_IDLE;
                    end
                end
                default: begin
                    mem_state_r <= audio_in_pkg::MEM_IDLE;
                end
            endcase
        end
    end

    assign mem_valid = (mem_state_r == audio_in_pkg::MEM_BUSY);
    assign mem_addr = mem_addr_r;
    assign mem_data = mem_data_r;

    // Register storage; a new full or overrun event wins over a clear in the same cycle.
    wire [1:0] full_clear = wr_status ? reg_wdata[`STAT_BUF2_FULL:`STAT_BUF1_FULL] : 2'b00;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_r <= `CTRL_RESET;
            frequency_r <= 32'h00000000;
            bit_clock_divider_r <= 8'h00;
            frame_length_divider_r <= 9'h000;
            valid_bit_position_r <= 9'h000;
            left_start_r <= `LEFT_START_RESET;
            right_start_r <= `RIGHT_START_RESET;
            data_length_r <= `DATA_LENGTH_RESET;
            base1_r <= 32'h00000000;
            base2_r <= 32'h00000000;
            buf_words_r <= `BUF_WORDS_RESET;
            buf_full_r <= 2'b00;
            overrun_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata[`CTRL_WIDTH-1:0];
            end
            if (wr_freq) begin
                frequency_r <= reg_wdata;
            end
            if (wr_div) begin
                bit_clock_divider_r <= reg_wdata[7:0];
                frame_length_divider_r <= reg_wdata[`FLDIV_LSB+8:`FLDIV_LSB];
            end
            if (wr_frame_a) begin
                valid_bit_position_r <= reg_wdata[8:0];
                left_start_r <= reg_wdata[`SECOND_LSB+8:`SECOND_LSB];
            end
            if (wr_frame_b) begin
                right_start_r <= reg_wdata[8:0];
                data_length_r <= (reg_wdata[`SECOND_LSB+4:`SECOND_LSB] == 5'h00) ? 5'h01 :
                    ((reg_wdata[`SECOND_LSB+4:`SECOND_LSB] > 5'h10) ? 5'h10 : reg_wdata[`SECOND_LSB+4:`SECOND_LSB]);
            end
            if (wr_base1) begin
                base1_r <= {reg_wdata[31:2], 2'b00};
            end
            if (wr_base2) begin
                base2_r <= {reg_wdata[31:2], 2'b00};
            end
            if (wr_words) begin
                buf_words_r <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
            end
            buf_full_r <= (buf_full_r & ~full_clear) | full_set;
            overrun_r <= (overrun_r & ~(wr_status & reg_wdata[`STAT_OVERRUN])) | overrun_set;
        end
    end

    // Read path: data stand in the cycle after the strobe only.
    wire [31:0] status_word = {28'h0000000, active_buf_r, overrun_r, buf_full_r};
    wire [31:0] rd_value =
        hit(reg_addr, `AIN_CTRL_OFS) ? {22'h000000, ctrl_r} :
        hit(reg_addr, `AIN_STATUS_OFS) ? status_word :
        hit(reg_addr, `AIN_FREQUENCY_OFS) ? frequency_r :
        hit(reg_addr, `AIN_DIVIDER_OFS) ? {7'h00, frame_length_divider_r, 8'h00, bit_clock_divider_r} :
        hit(reg_addr, `AIN_FRAME_A_OFS) ? {7'h00, left_start_r, 7'h00, valid_bit_position_r} :
        hit(reg_addr, `AIN_FRAME_B_OFS) ? {11'h000, data_length_r, 7'h00, right_start_r} :
        hit(reg_addr, `AIN_BASE1_OFS) ? base1_r :
        hit(reg_addr, `AIN_BASE2_OFS) ? base2_r :
        hit(reg_addr, `AIN_BUF_WORDS_OFS) ? {16'h0000, buf_words_r} :
        hit(reg_addr, `AIN_SAMPLE_OFS) ? {sample_right_r, sample_left_r} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_r <= 32'h00000000;
        end else begin
            reg_rdata_r <= reg_read ? rd_value : 32'h00000000;
        end
    end

    assign reg_rdata = reg_rdata_r;

endmodule : audio_in_serial_port

//--- logic/audio_in_regs.svh
`ifndef AUDIO_IN_REGS_SVH
`define AUDIO_IN_REGS_SVH

// Register byte offsets.
`define AIN_CTRL_OFS 8'h00
`define AIN_STATUS_OFS 8'h04
`define AIN_FREQUENCY_OFS 8'h08
`define AIN_DIVIDER_OFS 8'h0c
`define AIN_FRAME_A_OFS 8'h10
`define AIN_FRAME_B_OFS 8'h14
`define AIN_BASE1_OFS 8'h18
`define AIN_BASE2_OFS 8'h1c
`define AIN_BUF_WORDS_OFS 8'h20
`define AIN_SAMPLE_OFS 8'h24

// Control register fields.
`define CTRL_ENABLE 0
`define CTRL_MASTER 1
`define CTRL_EDGE_RISING 2
`define CTRL_WS_POLARITY 3
`define CTRL_LITTLE_ENDIAN 4
`define CTRL_STEREO 5
`define CTRL_SIZE16 6
`define CTRL_MSB_FIRST 7
`define CTRL_QUAL_LO 8
`define CTRL_QUAL_HI 9
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h0cd

// Status register fields.
`define STAT_BUF1_FULL 0
`define STAT_BUF2_FULL 1
`define STAT_OVERRUN 2
`define STAT_ACTIVE_BUF 3

// Divider and framing field positions.
`define FLDIV_LSB 16
`define SECOND_LSB 16

// Reset values.
`define DATA_LENGTH_RESET 5'h10
`define LEFT_START_RESET 9'h000
`define RIGHT_START_RESET 9'h010
`define BUF_WORDS_RESET 16'h0100

`endif

//--- logic/audio_in_pkg.sv
package audio_in_pkg;

    typedef enum logic [0:0] {
        MEM_IDLE = 1'b0,
        MEM_BUSY = 1'b1
    } mem_state_t;

    typedef enum logic [1:0] {
        LAYOUT_8_MONO = 2'b00,
        LAYOUT_8_STEREO = 2'b01,
        LAYOUT_16_MONO = 2'b10,
        LAYOUT_16_STEREO = 2'b11
    } sample_layout_t;

endpackage : audio_in_pkg

//--- verification/audio_in_serial_port_properties.sv
`timescale 1ns/10ps
`include "audio_in_regs.svh"

module audio_in_serial_port_checker (
    // System side
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Converter side
    input wire logic oversample_clock_out,
    input wire logic serial_bit_clock_out,
    input wire logic serial_bit_clock_oe,
    input wire logic frame_word_select_out,
    input wire logic frame_word_select_oe,
    // Memory side
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_data,
    input wire logic mem_ready
);
    logic [9:0] ctrl_r;
    logic [31:0] freq_r;
    logic os_used_r;
    logic [3:0] quiet_r;

    // Quiet counts cycles since any write, so checks skip the cycles where new settings are still landing.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_r <= `CTRL_RESET;
            freq_r <= 32'h0;
            os_used_r <= 1'b0;
            quiet_r <= 4'hf;
        end else begin
            if (reg_write && reg_addr == `AIN_CTRL_OFS) begin
                ctrl_r <= reg_wdata[9:0];
            end
            if (reg_write && reg_addr == `AIN_FREQUENCY_OFS) begin
                freq_r <= reg_wdata;
                os_used_r <= 1'b1;
            end
            quiet_r <= reg_write ? 4'h0 : ((quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_ctrl_readback: assert property (reg_read && reg_addr == `AIN_CTRL_OFS |=> reg_rdata[9:0] == ctrl_r)
        else $error("control readback differs from last write");
    a_pin_direction: assert property (quiet_r > 4'h2 |-> serial_bit_clock_oe == ctrl_r[1]
        && frame_word_select_oe == ctrl_r[1])
        else $error("pin direction does not follow master bit");
    a_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data))
        else $error("memory request changed before acceptance");
    a_mem_once: assert property (mem_valid && mem_ready |=> !mem_valid)
        else $error("memory word offered twice");
    a_os_idle: assert property (!os_used_r |-> !oversample_clock_out)
        else $error("oversampling clock runs with no frequency set");
    a_os_toggle: assert property (freq_r == 32'h8000_0000 && quiet_r > 4'h3 |=> $changed(oversample_clock_out))
        else $error("oversampling clock not at half rate");
    a_ws_opposite: assert property (ctrl_r[1] && quiet_r > 4'h3 && $changed(frame_word_select_out)
        |-> serial_bit_clock_out == !ctrl_r[2])
        else $error("word select moved on the sampling edge");
endmodule : audio_in_serial_port_checker

bind audio_in_serial_port audio_in_serial_port_checker chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .oversample_clock_out(oversample_clock_out), .serial_bit_clock_out(serial_bit_clock_out),
    .serial_bit_clock_oe(serial_bit_clock_oe), .frame_word_select_out(frame_word_select_out),
    .frame_word_select_oe(frame_word_select_oe), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_ready(mem_ready));

//--- verification/audio_adc_model.sv
`timescale 1ns/10ps

module audio_adc_model (
    // Serial pins
    output logic bit_clock,
    output logic word_select,
    output logic data
);
    // Half period unrelated in phase to the 40 ns system clock and slow enough for the oversampling receiver.
    localparam int HALF = 190;
    logic [31:0] frame_q[$];

    initial begin
        bit_clock = 1'b0;
        word_select = 1'b0;
        data = 1'b0;
    end

    task automatic slot(input logic ws, input logic d);
        word_select = ws;
        data = d;
        #HALF bit_clock = 1'b1;
        #HALF bit_clock = 1'b0;
    endtask : slot

    // Left in the upper half of each queued word, both channels MSB first, select one slot ahead of data.
    // A low then high select slot opens each burst, so the receiver always sees a fresh frame start.
    task automatic play();
        logic [31:0] w;
        slot(1'b0, 1'b0);
        slot(1'b1, 1'b1);
        while (frame_q.size() > 0) begin
            w = frame_q.pop_front();
            for (int k = 0; k < 32; k++) begin
                slot(k < 15 || k == 31, w[31 - k]);
            end
        end
    endtask : play
endmodule : audio_adc_model

//--- verification/tb_audio_in_serial_port.sv
`timescale 1ns/10ps
`include "audio_in_regs.svh"

module tb_audio_in_serial_port;
    logic clk, reset_n, reg_write, reg_read, mem_ready, mem_valid;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_data;
    logic os_clk, bclk_out, bclk_oe, ws_out, ws_oe, adc_bclk, adc_ws, adc_data, bclk_d, ws_d;
    logic [1:0] stall;
    int cyc, bclk_per, nb, frame_bits, mismatches, n_tests;
    logic [31:0] addr_q[$], data_q[$];
    // Each pin carries whichever side has its enable up.
    wire sck_pin = bclk_oe ? bclk_out : adc_bclk;
    wire ws_pin = ws_oe ? ws_out : adc_ws;

    audio_in_serial_port uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .oversample_clock_out(os_clk),
        .serial_bit_clock_in(sck_pin), .serial_bit_clock_out(bclk_out), .serial_bit_clock_oe(bclk_oe),
        .frame_word_select_in(ws_pin), .frame_word_select_out(ws_out), .frame_word_select_oe(ws_oe),
        .serial_data_in(adc_data), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_ready(mem_ready));
    audio_adc_model adc (.bit_clock(adc_bclk), .word_select(adc_ws), .data(adc_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Memory accepts one cycle in four; bit clock period and frame length are measured in master mode.
    always @(posedge clk) begin
        stall <= stall + 2'h1;
        mem_ready <= (stall == 2'h3);
        if (mem_valid && mem_ready) begin
            addr_q.push_back(mem_addr);
            data_q.push_back(mem_data);
        end
        bclk_d <= bclk_out;
        ws_d <= ws_out;
        if (bclk_out && !bclk_d) begin
            bclk_per <= cyc;
            cyc <= 1;
            nb <= nb + 1;
        end else begin
            cyc <= cyc + 1;
        end
        if (ws_out && !ws_d) begin
            frame_bits <= nb;
            nb <= 0;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
        @(posedge clk);
    endtask : reg_rd

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_words(input int n);
        @(posedge clk);
        for (int i = 0; i < 2000 && addr_q.size() < n; i++) @(posedge clk);
        if (addr_q.size() < n) begin
            mismatches++;
            print_verdict();
        end
    endtask : wait_words

    initial begin
        #2000000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {reset_n, reg_write, reg_read, mem_ready, bclk_d, ws_d, stall} = '0;
        {reg_addr, reg_wdata, cyc, nb, bclk_per, frame_bits, mismatches, n_tests} = '0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        reg_rd(`AIN_CTRL_OFS, {22'h0, `CTRL_RESET});
        reg_rd(`AIN_FRAME_B_OFS, 32'h0010_0010);
        reg_rd(`AIN_BUF_WORDS_OFS, 32'h0000_0100);
        reg_rd(`AIN_STATUS_OFS, 32'h0);
        reg_rd(8'h28, 32'h0);
        check({31'h0, bclk_oe | ws_oe}, 32'h0);
        // One stereo word per buffer: two frames fill both and the second finds the first still full.
        reg_wr(`AIN_BASE1_OFS, 32'h0000_1003);
        reg_rd(`AIN_BASE1_OFS, 32'h0000_1000);
        reg_wr(`AIN_BASE2_OFS, 32'h0000_2000);
        reg_wr(`AIN_BUF_WORDS_OFS, 32'h1);
        reg_wr(`AIN_CTRL_OFS, 32'h0fd);
        adc.frame_q = '{32'h1234_abcd, 32'h8001_7ffe};
        adc.play();
        wait_words(2);
        check(addr_q[0], 32'h1000);
        check(data_q[0], 32'habcd_1234);
        check(addr_q[1], 32'h2000);
        check(data_q[1], 32'h7ffe_8001);
        repeat (4) @(posedge clk);
        reg_rd(`AIN_STATUS_OFS, 32'h7);
        reg_wr(`AIN_STATUS_OFS, 32'h4);
        reg_rd(`AIN_STATUS_OFS, 32'h3);
        // Qualified capture, big endian: only the frame whose closing bit is one is kept.
        reg_wr(`AIN_CTRL_OFS, 32'h0ec);
        reg_wr(`AIN_FRAME_A_OFS, 32'h0000_001f);
        reg_wr(`AIN_CTRL_OFS, 32'h3ed);
        adc.frame_q = '{32'hffff_fffe, 32'h5a3c_0ff1};
        adc.play();
        wait_words(3);
        repeat (40) @(posedge clk);
        check(32'(addr_q.size()), 32'h3);
        check(data_q[2], 32'hf10f_3c5a);
        // Master: oversampling at a quarter of clk, bit clock halved, four-bit frames.
        reg_wr(`AIN_FREQUENCY_OFS, 32'h8000_0000);
        repeat (8) @(posedge clk);
        reg_wr(`AIN_FREQUENCY_OFS, 32'h4000_0000);
        reg_wr(`AIN_DIVIDER_OFS, 32'h0003_0001);
        reg_wr(`AIN_CTRL_OFS, 32'h0cf);
        repeat (200) @(posedge clk);
        check({31'h0, bclk_oe & ws_oe}, 32'h1);
        check(32'(bclk_per), 32'h8);
        check(32'(frame_bits), 32'h4);
        print_verdict();
    end
endmodule : tb_audio_in_serial_port
